// ### common/vw_flag_pkg.sv
package vw_flag_pkg;

	// Datapath widths
	localparam int unsigned CNT_W   = 16;
	localparam int unsigned IOC_W   = 5;
	localparam int unsigned PHASES  = 2;

	// Phase indices into the per-phase arrays
	localparam int unsigned PHASE_V = 0;
	localparam int unsigned PHASE_W = 1;

	// Status write data bit positions
	localparam int unsigned FLAG_V_BIT = 1;
	localparam int unsigned FLAG_W_BIT = 0;
	localparam int unsigned STAT_W     = 2;

	// Reset values
	localparam logic             FLAG_RESET = 1'h0;
	localparam logic [CNT_W-1:0] GR_RESET   = 16'hFFFF;
	localparam logic [2:0]       SYNC_RESET = 3'h0;

	// Encodings of the I/O control selection field
	localparam logic [IOC_W-1:0] IOC_OFF        = 5'h00;
	localparam logic [IOC_W-1:0] IOC_COMPARE    = 5'h01;
	localparam logic [IOC_W-1:0] IOC_CAP_RISE   = 5'h11;
	localparam logic [IOC_W-1:0] IOC_CAP_FALL   = 5'h12;
	localparam logic [IOC_W-1:0] IOC_CAP_BOTH   = 5'h13;
	localparam logic [IOC_W-1:0] IOC_PW_LOW     = 5'h15;
	localparam logic [IOC_W-1:0] IOC_PW_HIGH    = 5'h16;
	localparam logic [IOC_W-1:0] IOC_PW_BOTH    = 5'h17;

	// Kind of use selected by the field
	typedef enum logic [1:0] {
		USE_NONE,
		USE_COMPARE,
		USE_CAPTURE,
		USE_PULSE_WIDTH
	} reg_use_e;

endpackage : vw_flag_pkg

// ### src/pin_edge_sync.sv
`timescale 1ns/1ns
module pin_edge_sync
	import vw_flag_pkg::*;
(
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	// Asynchronous pin
	input  wire logic pin_i,
	// Filtered edges, same cycle as the accepted change
	output logic      rise_o,
	output logic      fall_o
);

	logic [2:0] sync_q;
	logic       level_q;
	logic       stable;

	// Three-stage chain; stage 0 only feeds stage 1
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_q <= SYNC_RESET;
		end else begin
			sync_q <= {sync_q[1:0], pin_i};
		end
	end

	// A change counts only once stages 1 and 2 agree
	assign stable = (sync_q[1] == sync_q[2]);

	// Accepted level, so one pin edge gives at most one pulse
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			level_q <= 1'h0;
		end else if (stable) begin
			level_q <= sync_q[2];
		end
	end

	// Edge pulses
	assign rise_o = stable && sync_q[2] && !level_q;
	assign fall_o = stable && !sync_q[2] && level_q;

endmodule : pin_edge_sync

// ### src/phase_vw_match_capture_flags.sv
//Contract
//- V flag sets when V counter equals V general register in compare use.
//- V flag sets when a capture edge copies V counter into V general register.
//- V flag sets when pulse-width measurement copies V counter into V register.
//- V flag clears only on a write of 0 after reading it as 1.
//- W flag sets when W counter equals W general register in compare use.
//- W flag sets when a capture edge copies W counter into W general register.
//- W flag sets when pulse-width measurement copies W counter into W register.
//- W flag clears only on a write of 0 after reading it as 1.
//- No other clearing path; writing 1 never changes either flag.
//- Pulse-width transfer timing follows each phase's own io_control_select field.
`timescale 1ns/1ns
module phase_vw_match_capture_flags
	import vw_flag_pkg::*;
(
	// Clock and reset
	input  wire logic             mclk_i,
	input  wire logic             reset_n_i,
	// External pulse inputs
	input  wire logic             phase_v_pin_i,
	input  wire logic             phase_w_pin_i,
	// Counter values from the timer datapath
	input  wire logic [CNT_W-1:0] phase_v_counter_i,
	input  wire logic [CNT_W-1:0] phase_w_counter_i,
	// I/O control selection fields
	input  wire logic [IOC_W-1:0] phase_v_io_control_select_i,
	input  wire logic [IOC_W-1:0] phase_w_io_control_select_i,
	// Software write of the general registers
	input  wire logic             phase_v_general_reg_wr_i,
	input  wire logic             phase_w_general_reg_wr_i,
	input  wire logic [CNT_W-1:0] general_reg_wdata_i,
	// Status register access
	input  wire logic             status_rd_i,
	input  wire logic             status_wr_i,
	input  wire logic [STAT_W-1:0] status_wdata_i,
	// Flags and general register contents
	output logic                  phase_v_event_flag_o,
	output logic                  phase_w_event_flag_o,
	output logic [CNT_W-1:0]      phase_v_general_reg_o,
	output logic [CNT_W-1:0]      phase_w_general_reg_o
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Kind of use selected by an I/O control field
	function automatic reg_use_e use_of(input logic [IOC_W-1:0] io_control_select);
		reg_use_e u;
		u = USE_NONE;
		case (io_control_select)
			IOC_COMPARE:                              u = USE_COMPARE;
			IOC_CAP_RISE, IOC_CAP_FALL, IOC_CAP_BOTH: u = USE_CAPTURE;
			IOC_PW_LOW, IOC_PW_HIGH, IOC_PW_BOTH:     u = USE_PULSE_WIDTH;
			default:                                  u = USE_NONE;
		endcase
		return u;
	endfunction : use_of

	// Whether a pin edge causes a counter-to-register transfer
	function automatic logic transfer_due(input logic [IOC_W-1:0] io_control_select, input logic rise, input logic fall);
		logic t;
		t = 1'h0;
		case (io_control_select)
			IOC_CAP_RISE: t = rise;
			IOC_CAP_FALL: t = fall;
			IOC_CAP_BOTH: t = rise | fall;
			IOC_PW_LOW:   t = rise;         // End of a low pulse
			IOC_PW_HIGH:  t = fall;         // End of a high pulse
			IOC_PW_BOTH:  t = rise | fall;  // Every pulse end
			default:      t = 1'h0;
		endcase
		return t;
	endfunction : transfer_due

	////////////////////////////////////////////////////////////////////////
	// Per-phase views of the ports

	logic [CNT_W-1:0] counter   [PHASES];
	logic [IOC_W-1:0] io_control_select       [PHASES];
	logic             gr_wr     [PHASES];
	logic             clr_bit   [PHASES];
	logic             rise      [PHASES];
	logic             fall      [PHASES];
	logic             pin       [PHASES];

	logic [CNT_W-1:0] gr_q      [PHASES];
	logic             flag_q    [PHASES];
	logic             armed_q   [PHASES];
	logic             match_q   [PHASES];
	logic             match_now [PHASES];
	logic             xfer      [PHASES];
	logic             set_ev    [PHASES];
	logic             clear_ok  [PHASES];

	assign counter[PHASE_V] = phase_v_counter_i;
	assign counter[PHASE_W] = phase_w_counter_i;
	assign io_control_select[PHASE_V]     = phase_v_io_control_select_i;
	assign io_control_select[PHASE_W]     = phase_w_io_control_select_i;
	assign gr_wr[PHASE_V]   = phase_v_general_reg_wr_i;
	assign gr_wr[PHASE_W]   = phase_w_general_reg_wr_i;
	assign clr_bit[PHASE_V] = !status_wdata_i[FLAG_V_BIT];
	assign clr_bit[PHASE_W] = !status_wdata_i[FLAG_W_BIT];
	assign pin[PHASE_V]     = phase_v_pin_i;
	assign pin[PHASE_W]     = phase_w_pin_i;

	////////////////////////////////////////////////////////////////////////
	// Per-phase logic

	for (genvar p = 0; p < PHASES; p++) begin : g_phase

		// Pins are asynchronous, so each passes the filtered chain
		pin_edge_sync u_sync (
			.mclk_i    (mclk_i),
			.reset_n_i (reset_n_i),
			.pin_i     (pin[p]),
			.rise_o    (rise[p]),
			.fall_o    (fall[p])
		);

		// Equality in compare use
		assign match_now[p] = (use_of(io_control_select[p]) == USE_COMPARE) && (counter[p] == gr_q[p]);

		// Capture and pulse-width transfers, timed by the phase's own field
		assign xfer[p] = transfer_due(io_control_select[p], rise[p], fall[p]);

		// Match counts on its first cycle only; a counter parked on the
		// compare value must not re-raise a flag software just cleared
		assign set_ev[p] = (match_now[p] && !match_q[p]) || xfer[p];

		// Clearing write: 0 in the bit, and a prior read saw the flag at 1
		assign clear_ok[p] = status_wr_i && clr_bit[p] && armed_q[p];

		// Previous match state for the first-cycle detect
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				match_q[p] <= 1'h0;
			end else begin
				match_q[p] <= match_now[p];
			end
		end

		// General register: captured counter wins over a software write
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				gr_q[p] <= GR_RESET;
			end else if (xfer[p]) begin
				gr_q[p] <= counter[p];
			end else if (gr_wr[p]) begin
				gr_q[p] <= general_reg_wdata_i;
			end
		end

		// Read-as-1 arming; a new set between read and write disarms,
		// so software must read again before the clear takes effect
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				armed_q[p] <= 1'h0;
			end else if (set_ev[p] || status_wr_i) begin
				armed_q[p] <= 1'h0;
			end else if (status_rd_i) begin
				armed_q[p] <= flag_q[p];
			end
		end

		// Sticky flag; set beats clear, writes of 1 do nothing
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				flag_q[p] <= FLAG_RESET;
			end else if (set_ev[p]) begin
				flag_q[p] <= 1'h1;
			end else if (clear_ok[p]) begin
				flag_q[p] <= 1'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, straight from the flops

	assign phase_v_event_flag_o  = flag_q[PHASE_V];
	assign phase_w_event_flag_o  = flag_q[PHASE_W];
	assign phase_v_general_reg_o = gr_q[PHASE_V];
	assign phase_w_general_reg_o = gr_q[PHASE_W];

endmodule : phase_vw_match_capture_flags

// ### tb/vw_pin_model.sv
`timescale 1ns/1ns
// Pulse source on the capture pins; idle low
module vw_pin_model (
	// Clock
	input  wire logic mclk_i,
	// Pins toward the timer
	output logic      pin_v_o,
	output logic      pin_w_o
);
	logic [1:0] pins_q = 2'h0;
	// Pulses under 2 cycles would be lost in the sync chain
	assign pin_v_o = pins_q[0];
	assign pin_w_o = pins_q[1];
	task pulse(input int ph, input int width);
		@(negedge mclk_i);
		pins_q[ph] = 1'h1;
		repeat (width) @(negedge mclk_i);
		pins_q[ph] = 1'h0;
	endtask : pulse
endmodule : vw_pin_model

// ### tb/phase_vw_match_capture_flags_monitor.sv
`timescale 1ns/1ns
module phase_vw_match_capture_flags_monitor
	import vw_flag_pkg::*;
(
	// Clock and reset
	input wire logic              mclk_i,
	input wire logic              reset_n_i,
	// Watched inputs
	input wire logic [CNT_W-1:0]  phase_v_counter_i,
	input wire logic [CNT_W-1:0]  phase_w_counter_i,
	input wire logic [IOC_W-1:0]  phase_v_io_control_select_i,
	input wire logic [IOC_W-1:0]  phase_w_io_control_select_i,
	input wire logic              phase_v_general_reg_wr_i,
	input wire logic              phase_w_general_reg_wr_i,
	input wire logic              status_wr_i,
	input wire logic [STAT_W-1:0] status_wdata_i,
	// Watched outputs
	input wire logic              phase_v_event_flag_o,
	input wire logic              phase_w_event_flag_o,
	input wire logic [CNT_W-1:0]  phase_v_general_reg_o,
	input wire logic [CNT_W-1:0]  phase_w_general_reg_o
);
	// Compare hits, before the flag reacts
	wire logic mv = phase_v_io_control_select_i == IOC_COMPARE && phase_v_counter_i == phase_v_general_reg_o;
	wire logic mw = phase_w_io_control_select_i == IOC_COMPARE && phase_w_counter_i == phase_w_general_reg_o;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	a_reset_flags_low: assert property ($rose(reset_n_i) |-> !phase_v_event_flag_o && !phase_w_event_flag_o)
		else $error("flag high after reset");
	a_v_clear_cause: assert property ($fell(phase_v_event_flag_o) |-> $past(status_wr_i && !status_wdata_i[1]))
		else $error("v flag fell without write");
	a_w_clear_cause: assert property ($fell(phase_w_event_flag_o) |-> $past(status_wr_i && !status_wdata_i[0]))
		else $error("w flag fell without write");
	a_one_keeps_v: assert property (status_wr_i && status_wdata_i[1] && phase_v_event_flag_o |=> phase_v_event_flag_o)
		else $error("write of one changed v flag");
	a_one_keeps_w: assert property (status_wr_i && status_wdata_i[0] && phase_w_event_flag_o |=> phase_w_event_flag_o)
		else $error("write of one changed w flag");
	a_v_compare_set: assert property (mv && !$past(mv) |=> phase_v_event_flag_o)
		else $error("v compare did not set flag");
	a_w_compare_set: assert property (mw && !$past(mw) |=> phase_w_event_flag_o)
		else $error("w compare did not set flag");
	a_v_capture_set: assert property ($changed(phase_v_general_reg_o) && !$past(phase_v_general_reg_wr_i)
		|-> phase_v_event_flag_o) else $error("v transfer without flag");
	a_w_capture_set: assert property ($changed(phase_w_general_reg_o) && !$past(phase_w_general_reg_wr_i)
		|-> phase_w_event_flag_o) else $error("w transfer without flag");
	// Main scenarios reached
	c_v_capture: cover property ($changed(phase_v_general_reg_o) && !$past(phase_v_general_reg_wr_i));
	c_v_cleared: cover property ($fell(phase_v_event_flag_o));
	c_w_cleared: cover property ($fell(phase_w_event_flag_o));
	c_w_compare: cover property (mw);
endmodule : phase_vw_match_capture_flags_monitor

// ### tb/phase_vw_match_capture_flags_tb.sv
`timescale 1ns/1ns
module phase_vw_match_capture_flags_tb import vw_flag_pkg::*;;
	// Stimulus, named as the ports
	logic              mclk_i = 1'h0;
	logic              reset_n_i = 1'h0;
	wire logic         phase_v_pin_i;
	wire logic         phase_w_pin_i;
	logic [CNT_W-1:0]  phase_v_counter_i = 16'h0000;
	wire logic [CNT_W-1:0] phase_w_counter_i = phase_v_counter_i + 16'h1000;
	logic [IOC_W-1:0]  phase_v_io_control_select_i = IOC_OFF;
	logic [IOC_W-1:0]  phase_w_io_control_select_i = IOC_OFF;
	logic              phase_v_general_reg_wr_i = 1'h0;
	logic              phase_w_general_reg_wr_i = 1'h0;
	logic [CNT_W-1:0]  general_reg_wdata_i = 16'h0000;
	logic              status_rd_i = 1'h0;
	logic              status_wr_i = 1'h0;
	logic [STAT_W-1:0] status_wdata_i = 2'h3;
	logic              phase_v_event_flag_o;
	logic              phase_w_event_flag_o;
	logic [CNT_W-1:0]  phase_v_general_reg_o;
	logic [CNT_W-1:0]  phase_w_general_reg_o;
	int                fails = 0;
	int                num_checks = 0;
	int                cycles = 0;
	// Capture and pulse-width modes, and whether the last transfer sits on the falling pin edge
	logic [IOC_W-1:0]  modes[6] = '{IOC_CAP_RISE, IOC_CAP_FALL, IOC_CAP_BOTH, IOC_PW_LOW, IOC_PW_HIGH, IOC_PW_BOTH};
	bit                at_fall[6] = '{0, 1, 1, 0, 1, 1};
	phase_vw_match_capture_flags phase_vw_match_capture_flags_i (.*);
	vw_pin_model vw_pin_model_i (.mclk_i, .pin_v_o(phase_v_pin_i), .pin_w_o(phase_w_pin_i));
	////////////////////////////////////////////////////////////
	always #5 mclk_i = ~mclk_i;
	// Free counter and hang guard
	always @(negedge mclk_i) begin
		phase_v_counter_i <= phase_v_counter_i + 16'h0001;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails++;
			stop_test();
		end
	end
	function logic flag(input int ph);
		return ph ? phase_w_event_flag_o : phase_v_event_flag_o;
	endfunction : flag
	function logic [CNT_W-1:0] gr(input int ph);
		return ph ? phase_w_general_reg_o : phase_v_general_reg_o;
	endfunction : gr
	task chk(input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask : chk
	task set_use(input int ph, input logic [IOC_W-1:0] m);
		if (ph == 0)
			phase_v_io_control_select_i = m;
		else
			phase_w_io_control_select_i = m;
	endtask : set_use
	// One status access, strobes dropped a cycle later
	task st(input logic rd, input logic wr, input logic [STAT_W-1:0] wd);
		@(negedge mclk_i);
		status_rd_i = rd;
		status_wr_i = wr;
		status_wdata_i = wd;
		@(negedge mclk_i);
		status_rd_i = 1'h0;
		status_wr_i = 1'h0;
	endtask : st
	task cmp_case(input int ph);
		logic [CNT_W-1:0] tgt;
		@(negedge mclk_i);
		set_use(ph, IOC_COMPARE);
		tgt = phase_v_counter_i + (ph ? 16'h1020 : 16'h0020);
		general_reg_wdata_i = tgt;
		{phase_w_general_reg_wr_i, phase_v_general_reg_wr_i} = 2'h1 << ph;
		@(negedge mclk_i);
		{phase_w_general_reg_wr_i, phase_v_general_reg_wr_i} = 2'h0;
		chk(tgt, gr(ph));
		repeat (20) @(negedge mclk_i);
		chk(16'h0000, flag(ph));
		repeat (20) @(negedge mclk_i);
		chk(16'h0001, flag(ph));
		chk(16'h0000, flag(1 - ph));
		// Armed clear lands on the edge of a fresh match five edges on; set must win
		@(negedge mclk_i);
		general_reg_wdata_i = (ph ? phase_w_counter_i : phase_v_counter_i) + 16'h0005;
		{phase_w_general_reg_wr_i, phase_v_general_reg_wr_i} = 2'h1 << ph;
		@(negedge mclk_i);
		{phase_w_general_reg_wr_i, phase_v_general_reg_wr_i} = 2'h0;
		st(1'h1, 1'h0, 2'h3);
		st(1'h0, 1'h1, 2'h0);
		chk(16'h0001, flag(ph));
		st(1'h0, 1'h1, 2'h0);
		chk(16'h0001, flag(ph));
		st(1'h1, 1'h0, 2'h3);
		st(1'h0, 1'h1, 2'h3);
		chk(16'h0001, flag(ph));
		st(1'h1, 1'h0, 2'h3);
		st(1'h0, 1'h1, 2'h0);
		chk(16'h0000, flag(ph));
		set_use(ph, IOC_OFF);
	endtask : cmp_case
	// Transfer lands on the 4th rising edge after the chosen pin edge
	task cap_case(input int ph, input int k);
		logic [CNT_W-1:0] ref_cnt;
		logic [CNT_W-1:0] got;
		set_use(ph, modes[k]);
		vw_pin_model_i.pulse(ph, 6);
		ref_cnt = (ph ? phase_w_counter_i : phase_v_counter_i) - (at_fall[k] ? 16'h0000 : 16'h0006);
		repeat (8) @(negedge mclk_i);
		got = gr(ph);
		chk(16'h0001, flag(ph));
		chk(16'h0001, 16'(got - ref_cnt - 16'h0002 <= 16'h0003));
		st(1'h1, 1'h0, 2'h3);
		st(1'h0, 1'h1, 2'h0);
		chk(16'h0000, flag(ph));
		set_use(ph, IOC_OFF);
	endtask : cap_case
	////////////////////////////////////////////////////////////
	task stop_test();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : stop_test
	initial begin
		repeat (8) @(negedge mclk_i);
		reset_n_i = 1'h1;
		chk(16'h0000, flag(0));
		chk(16'h0000, flag(1));
		for (int ph = 0; ph < 2; ph++) begin
			cmp_case(ph);
			for (int k = 0; k < 6; k++)
				cap_case(ph, k);
		end
		stop_test();
	end
endmodule : phase_vw_match_capture_flags_tb
bind phase_vw_match_capture_flags phase_vw_match_capture_flags_monitor phase_vw_match_capture_flags_monitor_i (.*);
